// File: spc_core.sv
// Purpose: privilege check and execution of system instructions
// Assumes: one instruction per cycle, result one cycle later
// Notes: Avalon-MM slave, one wait cycle per access
// Contract
// - load, control, cache, halt, model ops complete only at level 0
// - store forms, adjust, rights, limit, verify, lock run at any level
// - at levels 1 to 3 counter and timestamp reads gated by two flags
// - restrict flag set: timestamp read only at level 0
// - counter open flag set: counter read at any level, else level 0
// - global table load writes base and limit; store returns both
// - interrupt table load writes base and limit; store returns both
// - local table load takes selector and descriptor; store returns selector
// - task load takes selector and descriptor; store returns selector
// - low word load and store touch only bits 0 to 15
// - switched flag clear resets the task switched flag
// - switched flag set: floating-point op raises device-unavailable fault
// - control move copies data to or from control registers 0 to 4
// - adjust raises selector requestor level to the supplier's level
// - access rights load checks segment then returns its rights
// - limit load checks segment then returns its limit
// - verify reports readable or writable with no fault
`timescale 1ns/1ps

module spc_core (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic INS_VALID,
  input wire spc_pkg::spc_req_t INS_REQ,
  output spc_pkg::spc_res_t RES,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] cr [spc_pkg::CR_COUNT];
  logic [31:0] next_cr [spc_pkg::CR_COUNT];
  spc_pkg::spc_tbl_t gdt, idt;
  spc_pkg::spc_seg_t ldt, tr;
  logic [63:0] tsc;
  logic [31:0] pmc;
  logic [spc_pkg::EV_W-1:0] status, irq_en;
  spc_pkg::spc_res_t next_res;

  // ----------------------------------------------------------------
  // privilege decode
  // ----------------------------------------------------------------
  spc_pkg::spc_op_t op;
  wire [1:0] current_privilege_level = INS_REQ.current_privilege_level;
  wire kernel = current_privilege_level == spc_pkg::PL_KERNEL;
  assign op = INS_REQ.op;
  wire is_priv = op inside {spc_pkg::OP_LOAD_GLOBAL_TABLE_BASE, spc_pkg::OP_LOAD_INTERRUPT_TABLE_BASE,
    spc_pkg::OP_LOAD_LOCAL_TABLE_SELECTOR, spc_pkg::OP_LTR, spc_pkg::OP_MOV_TO_CR,
    spc_pkg::OP_MOV_FROM_CR, spc_pkg::OP_MOV_DR, spc_pkg::OP_LOAD_LOW_CONTROL_WORD,
    spc_pkg::OP_CLEAR_SWITCHED_FLAG_OP, spc_pkg::OP_INVALIDATE_NO_WRITEBACK_OP, spc_pkg::OP_INVALIDATE_WITH_WRITEBACK_OP,
    spc_pkg::OP_INVALIDATE_PAGE_ENTRY_OP, spc_pkg::OP_HLT, spc_pkg::OP_RSM,
    spc_pkg::OP_READ_MODEL_REG_OP, spc_pkg::OP_WRITE_MODEL_REG_OP};
  wire timestamp_restrict_flag = cr[spc_pkg::CR4_IDX][spc_pkg::CR4_TSD_BIT];
  wire perf_counter_open_flag = cr[spc_pkg::CR4_IDX][spc_pkg::CR4_PCE_BIT];
  wire ts_block = op == spc_pkg::OP_READ_TIMESTAMP_OP && timestamp_restrict_flag && !kernel;
  wire pc_block = op == spc_pkg::OP_READ_PERF_COUNTER_OP && !perf_counter_open_flag && !kernel;
  wire is_cr = op inside {spc_pkg::OP_MOV_TO_CR, spc_pkg::OP_MOV_FROM_CR};
  wire bad_cr = is_cr && INS_REQ.cr_idx >= 3'(spc_pkg::CR_COUNT);
  wire gp = INS_VALID &&
    ((is_priv && !kernel) || ts_block || pc_block || bad_cr);
  wire fpu_off = cr[spc_pkg::CR0_IDX][spc_pkg::CR0_TS_BIT] ||
    cr[spc_pkg::CR0_IDX][spc_pkg::CR0_EM_BIT];
  wire nm = INS_VALID && op == spc_pkg::OP_FPU && fpu_off;
  wire exec = INS_VALID && !gp && !nm;
  wire do_ = exec;

  // ----------------------------------------------------------------
  // segment checks
  // ----------------------------------------------------------------
  wire [7:0] rt = INS_REQ.rights;
  wire [1:0] dpl = rt[spc_pkg::RT_DPL_HI:spc_pkg::RT_DPL_LO];
  wire [1:0] requestor_level = INS_REQ.sel[1:0];
  wire conf = rt[spc_pkg::RT_SEG] && rt[spc_pkg::RT_CODE] &&
    rt[spc_pkg::RT_CONF];
  wire pl_ok = conf || (dpl >= current_privilege_level && dpl >= requestor_level);
  wire acc_ok = rt[spc_pkg::RT_PRESENT] && pl_ok;
  wire rd_ok = acc_ok && rt[spc_pkg::RT_SEG] &&
    (!rt[spc_pkg::RT_CODE] || rt[spc_pkg::RT_RW]);
  wire wr_ok = acc_ok && rt[spc_pkg::RT_SEG] &&
    !rt[spc_pkg::RT_CODE] && rt[spc_pkg::RT_RW];
  wire [1:0] src_rpl = INS_REQ.data[1:0];
  wire adjust_requestor_level_adj = requestor_level < src_rpl;

  // ----------------------------------------------------------------
  // result select
  // ----------------------------------------------------------------
  always_comb
  begin
    next_res = '0;
    next_res.valid = INS_VALID;
    next_res.fault = gp ? spc_pkg::FLT_GP :
      nm ? spc_pkg::FLT_NM : spc_pkg::FLT_NONE;
    if (exec)
    begin
      unique case (op)
        spc_pkg::OP_STORE_GLOBAL_TABLE_BASE:
        begin
          next_res.data = gdt.base;
          next_res.limit = gdt.limit;
        end
        spc_pkg::OP_STORE_INTERRUPT_TABLE_BASE:
        begin
          next_res.data = idt.base;
          next_res.limit = idt.limit;
        end
        spc_pkg::OP_STORE_LOCAL_TABLE_SELECTOR: next_res.data = {16'h0000, ldt.sel};
        spc_pkg::OP_STR: next_res.data = {16'h0000, tr.sel};
        spc_pkg::OP_MOV_FROM_CR: next_res.data = cr[INS_REQ.cr_idx];
        spc_pkg::OP_STORE_LOW_CONTROL_WORD: next_res.data =
          {16'h0000, cr[spc_pkg::CR0_IDX][spc_pkg::MSW_BITS-1:0]};
        spc_pkg::OP_ADJUST_REQUESTOR_LEVEL:
        begin
          next_res.zf = adjust_requestor_level_adj;
          next_res.data = {16'h0000, INS_REQ.sel[15:2],
            adjust_requestor_level_adj ? src_rpl : requestor_level};
        end
        spc_pkg::OP_LAR:
        begin
          next_res.zf = acc_ok;
          next_res.data = acc_ok ? {16'h0000, rt, 8'h00} : 32'h0000_0000;
        end
        spc_pkg::OP_LSL:
        begin
          next_res.zf = acc_ok;
          next_res.data = acc_ok ? {12'h000, INS_REQ.seg_limit} :
            32'h0000_0000;
        end
        spc_pkg::OP_VERIFY_READABLE_OP: next_res.zf = rd_ok;
        spc_pkg::OP_VERIFY_WRITABLE_OP: next_res.zf = wr_ok;
        spc_pkg::OP_READ_TIMESTAMP_OP: next_res.data = tsc[31:0];
        spc_pkg::OP_READ_PERF_COUNTER_OP: next_res.data = pmc;
        default: next_res.data = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  wire bus_wr = AVS_WRITE && !AVS_WAITREQUEST;
  wire bus_go = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  wire [31:0] be_mask;
  wire clr_hit = bus_wr && AVS_ADDRESS == spc_pkg::OFS_IRQ_CLR;
  wire en_hit = bus_wr && AVS_ADDRESS == spc_pkg::OFS_IRQ_EN;
  wire [spc_pkg::EV_W-1:0] clr_mask = clr_hit ?
    (AVS_WRITEDATA[spc_pkg::EV_W-1:0] & be_mask[spc_pkg::EV_W-1:0]) : '0;
  wire [spc_pkg::EV_W-1:0] events = {exec, nm, gp};
  wire [spc_pkg::EV_W-1:0] next_status = (status & ~clr_mask) | events;
  wire [spc_pkg::EV_W-1:0] next_en = en_hit ?
    ((irq_en & ~be_mask[spc_pkg::EV_W-1:0]) |
    (AVS_WRITEDATA[spc_pkg::EV_W-1:0] & be_mask[spc_pkg::EV_W-1:0])) :
    irq_en;
  wire [31:0] rd_val =
    AVS_ADDRESS == spc_pkg::OFS_CR0 ? cr[spc_pkg::CR0_IDX] :
    AVS_ADDRESS == spc_pkg::OFS_CR4 ? cr[spc_pkg::CR4_IDX] :
    AVS_ADDRESS == spc_pkg::OFS_STATUS ? {29'h0, status} :
    AVS_ADDRESS == spc_pkg::OFS_IRQ_EN ? {29'h0, irq_en} :
    AVS_ADDRESS == spc_pkg::OFS_SEL ? {ldt.sel, tr.sel} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // control register updates, instruction wins over bus
  // ----------------------------------------------------------------
  wire clear_switched_flag_op_go = do_ && op == spc_pkg::OP_CLEAR_SWITCHED_FLAG_OP;
  wire load_low_control_word_go = do_ && op == spc_pkg::OP_LOAD_LOW_CONTROL_WORD;
  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_be
    assign be_mask[8*g+7:8*g] = {8{AVS_BYTEENABLE[g]}};
  end
  for (g = 0; g < spc_pkg::CR_COUNT; g++)
  begin : g_cr
    localparam logic [4:0] OFS = (g == spc_pkg::CR0_IDX) ?
      spc_pkg::OFS_CR0 : spc_pkg::OFS_CR4;
    wire mov_hit = do_ && op == spc_pkg::OP_MOV_TO_CR &&
      INS_REQ.cr_idx == 3'(g);
    wire bus_hit = bus_wr && AVS_ADDRESS == OFS &&
      (g == spc_pkg::CR0_IDX || g == spc_pkg::CR4_IDX);
    wire [31:0] load_low_control_word_val = {cr[g][31:spc_pkg::MSW_BITS],
      INS_REQ.data[spc_pkg::MSW_BITS-1:0]};
    wire [31:0] clear_switched_flag_op_val = cr[g] &
      ~(32'h0000_0001 << spc_pkg::CR0_TS_BIT);
    wire is0 = g == spc_pkg::CR0_IDX;
    assign next_cr[g] = mov_hit ? INS_REQ.data :
      (is0 && load_low_control_word_go) ? load_low_control_word_val :
      (is0 && clear_switched_flag_op_go) ? clear_switched_flag_op_val :
      bus_hit ? ((cr[g] & ~be_mask) | (AVS_WRITEDATA & be_mask)) : cr[g];
    always_ff @(posedge MCLK or negedge RST_N)
    begin
      if (!RST_N)
        cr[g] <= (g == spc_pkg::CR0_IDX) ? spc_pkg::CR0_RESET :
          spc_pkg::CR4_RESET;
      else
        cr[g] <= next_cr[g];
    end
  end

  // ----------------------------------------------------------------
  // system table registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      gdt <= '0;
      idt <= '0;
      ldt <= '0;
      tr <= '0;
    end
    else if (do_)
    begin
      if (op == spc_pkg::OP_LOAD_GLOBAL_TABLE_BASE)
        gdt <= {INS_REQ.data, INS_REQ.limit};
      if (op == spc_pkg::OP_LOAD_INTERRUPT_TABLE_BASE)
        idt <= {INS_REQ.data, INS_REQ.limit};
      if (op == spc_pkg::OP_LOAD_LOCAL_TABLE_SELECTOR)
        ldt <= {INS_REQ.sel, INS_REQ.data, INS_REQ.limit};
      if (op == spc_pkg::OP_LTR)
        tr <= {INS_REQ.sel, INS_REQ.data, INS_REQ.limit};
    end
  end

  // ----------------------------------------------------------------
  // counters, results, bus and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tsc <= '0;
      pmc <= '0;
      RES <= '0;
      status <= '0;
      irq_en <= '0;
      IRQ <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
    end
    else
    begin
      tsc <= tsc + 64'h1;
      pmc <= pmc + {31'h0, exec};
      RES <= next_res;
      status <= next_status;
      irq_en <= next_en;
      IRQ <= |(next_status & next_en);
      AVS_WAITREQUEST <= !bus_go;
      AVS_READDATA <= bus_go ? rd_val : AVS_READDATA;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_priv_gp_fault: assert property (INS_VALID && is_priv && !kernel |=>
    RES.valid && RES.fault == spc_pkg::FLT_GP) else $error("priv op ran");
  a_any_level_ok: assert property (INS_VALID && op inside {spc_pkg::OP_STORE_GLOBAL_TABLE_BASE,
    spc_pkg::OP_STR, spc_pkg::OP_LAR, spc_pkg::OP_VERIFY_WRITABLE_OP} |=>
    RES.fault == spc_pkg::FLT_NONE) else $error("open op faulted");
  a_tsc_gate: assert property (INS_VALID && op == spc_pkg::OP_READ_TIMESTAMP_OP &&
    current_privilege_level == spc_pkg::PL_USER |=> RES.fault == ($past(timestamp_restrict_flag) ?
    spc_pkg::FLT_GP : spc_pkg::FLT_NONE)) else $error("tsc gate");
  a_pmc_gate: assert property (INS_VALID && op == spc_pkg::OP_READ_PERF_COUNTER_OP &&
    !kernel |=> RES.fault == ($past(perf_counter_open_flag) ?
    spc_pkg::FLT_NONE : spc_pkg::FLT_GP)) else $error("pmc gate");
  a_gdt_load_store: assert property (INS_VALID && kernel &&
    op == spc_pkg::OP_LOAD_GLOBAL_TABLE_BASE ##1 INS_VALID && op == spc_pkg::OP_STORE_GLOBAL_TABLE_BASE |=>
    RES.data == $past(INS_REQ.data, 2)) else $error("gdt lost");
  a_msw_high_kept: assert property (INS_VALID && kernel &&
    op == spc_pkg::OP_LOAD_LOW_CONTROL_WORD |=> cr[spc_pkg::CR0_IDX][31:16] ==
    $past(cr[spc_pkg::CR0_IDX][31:16])) else $error("msw high");
  a_clear_switched_flag_op_clears: assert property (INS_VALID && kernel &&
    op == spc_pkg::OP_CLEAR_SWITCHED_FLAG_OP |=> !cr[spc_pkg::CR0_IDX][spc_pkg::CR0_TS_BIT])
    else $error("ts not cleared");
  a_nm_on_ts: assert property (INS_VALID && op == spc_pkg::OP_FPU &&
    cr[spc_pkg::CR0_IDX][spc_pkg::CR0_TS_BIT] |=>
    RES.fault == spc_pkg::FLT_NM) else $error("no nm");
  a_gp_no_effect: assert property (gp |=> $stable(gdt) && $stable(tr) &&
    $stable(idt) && $stable(ldt)) else $error("gp side effect");
  c_user_gp: cover property (INS_VALID && is_priv && current_privilege_level == spc_pkg::PL_USER);
  c_nm_then_clear_switched_flag_op: cover property (nm ##[1:20] clear_switched_flag_op_go);
  c_bus_read: cover property (AVS_READ && !AVS_WAITREQUEST);

endmodule

// File: spc_pkg.sv
// Purpose: shared constants and types of the system instruction checker
// Assumes: one clock, 32-bit Avalon-MM register slave
// Notes: register offsets are byte addresses

package spc_pkg;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CR_COUNT = 5;
  localparam int CR0_EM_BIT = 2;
  localparam int CR0_TS_BIT = 3;
  localparam int CR4_TSD_BIT = 2;
  localparam int CR4_PCE_BIT = 8;
  localparam int MSW_BITS = 16;
  localparam int CR0_IDX = 0;
  localparam int CR4_IDX = 4;
  localparam logic [31:0] CR0_RESET = 32'h0000_0000;
  localparam logic [31:0] CR4_RESET = 32'h0000_0000;
  localparam logic [1:0] PL_KERNEL = 2'h0;
  localparam logic [1:0] PL_USER = 2'h3;

  // ----------------------------------------------------------------
  // descriptor access byte fields
  // ----------------------------------------------------------------
  localparam int RT_PRESENT = 7;
  localparam int RT_DPL_HI = 6;
  localparam int RT_DPL_LO = 5;
  localparam int RT_SEG = 4;
  localparam int RT_CODE = 3;
  localparam int RT_CONF = 2;
  localparam int RT_RW = 1;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CR0 = 5'h00;
  localparam logic [4:0] OFS_CR4 = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_IRQ_EN = 5'h0c;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h10;
  localparam logic [4:0] OFS_SEL = 5'h14;
  localparam int EV_GP = 0;
  localparam int EV_NM = 1;
  localparam int EV_DONE = 2;
  localparam int EV_W = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_LOAD_GLOBAL_TABLE_BASE, OP_STORE_GLOBAL_TABLE_BASE, OP_LOAD_INTERRUPT_TABLE_BASE, OP_STORE_INTERRUPT_TABLE_BASE, OP_LOAD_LOCAL_TABLE_SELECTOR, OP_STORE_LOCAL_TABLE_SELECTOR, OP_LTR, OP_STR,
    OP_MOV_TO_CR, OP_MOV_FROM_CR, OP_LOAD_LOW_CONTROL_WORD, OP_STORE_LOW_CONTROL_WORD, OP_CLEAR_SWITCHED_FLAG_OP, OP_ADJUST_REQUESTOR_LEVEL,
    OP_LAR, OP_LSL, OP_VERIFY_READABLE_OP, OP_VERIFY_WRITABLE_OP, OP_MOV_DR, OP_INVALIDATE_NO_WRITEBACK_OP, OP_INVALIDATE_WITH_WRITEBACK_OP,
    OP_INVALIDATE_PAGE_ENTRY_OP, OP_HLT, OP_RSM, OP_READ_MODEL_REG_OP, OP_WRITE_MODEL_REG_OP, OP_READ_PERF_COUNTER_OP, OP_READ_TIMESTAMP_OP,
    OP_LOCK, OP_FPU
  } spc_op_t;

  typedef enum logic [1:0] {FLT_NONE, FLT_GP, FLT_NM} spc_fault_t;

  typedef struct packed {
    spc_op_t op;
    logic [1:0] current_privilege_level;
    logic [2:0] cr_idx;
    logic [31:0] data;
    logic [15:0] limit;
    logic [15:0] sel;
    logic [7:0] rights;
    logic [19:0] seg_limit;
  } spc_req_t;

  typedef struct packed {
    logic valid;
    spc_fault_t fault;
    logic zf;
    logic [31:0] data;
    logic [15:0] limit;
  } spc_res_t;

  typedef struct packed {
    logic [31:0] base;
    logic [15:0] limit;
  } spc_tbl_t;

  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [15:0] limit;
  } spc_seg_t;

endpackage

// File: test_system_instruction_privilege_check.sv
// Purpose: self-checking bench of the system instruction checker
// Assumes: result one cycle after issue, bus wait taken from waitrequest
// Notes: byte enables at all ones except the byte lane test
`timescale 1ns/1ps

module test_system_instruction_privilege_check;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  logic MCLK, RST_N, INS_VALID, AVS_READ, AVS_WRITE;
  logic AVS_WAITREQUEST, IRQ;
  spc_pkg::spc_req_t INS_REQ, q;
  spc_pkg::spc_res_t RES, res, res2;
  logic [4:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [3:0] AVS_BYTEENABLE;
  logic [1:0] pl;
  int miscompares, checks_done;
  spc_pkg::spc_op_t priv_ops [16] = '{spc_pkg::OP_LOAD_GLOBAL_TABLE_BASE, spc_pkg::OP_LOAD_INTERRUPT_TABLE_BASE,
    spc_pkg::OP_LOAD_LOCAL_TABLE_SELECTOR, spc_pkg::OP_LTR, spc_pkg::OP_MOV_TO_CR,
    spc_pkg::OP_MOV_FROM_CR, spc_pkg::OP_LOAD_LOW_CONTROL_WORD, spc_pkg::OP_CLEAR_SWITCHED_FLAG_OP,
    spc_pkg::OP_MOV_DR, spc_pkg::OP_INVALIDATE_NO_WRITEBACK_OP, spc_pkg::OP_INVALIDATE_WITH_WRITEBACK_OP,
    spc_pkg::OP_INVALIDATE_PAGE_ENTRY_OP, spc_pkg::OP_HLT, spc_pkg::OP_RSM,
    spc_pkg::OP_READ_MODEL_REG_OP, spc_pkg::OP_WRITE_MODEL_REG_OP};
  spc_pkg::spc_op_t open_ops [11] = '{spc_pkg::OP_STORE_GLOBAL_TABLE_BASE, spc_pkg::OP_STORE_INTERRUPT_TABLE_BASE,
    spc_pkg::OP_STORE_LOCAL_TABLE_SELECTOR, spc_pkg::OP_STR, spc_pkg::OP_STORE_LOW_CONTROL_WORD, spc_pkg::OP_ADJUST_REQUESTOR_LEVEL,
    spc_pkg::OP_LAR, spc_pkg::OP_LSL, spc_pkg::OP_VERIFY_READABLE_OP, spc_pkg::OP_VERIFY_WRITABLE_OP,
    spc_pkg::OP_LOCK};

  spc_core i_spc_core (
    .MCLK(MCLK), .RST_N(RST_N), .INS_VALID(INS_VALID), .INS_REQ(INS_REQ),
    .RES(RES), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chkf(input spc_pkg::spc_fault_t exp);
    chk("fault", {30'h0, res.fault}, {30'h0, exp});
  endtask

  // one avalon access, held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d);
    @(posedge MCLK);
    AVS_READ <= ~wr;
    AVS_WRITE <= wr;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0)
      @(posedge MCLK);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  // issue a, then b on the next edge when two is set
  task automatic exec(input spc_pkg::spc_req_t a, input logic two,
      input spc_pkg::spc_req_t b);
    @(posedge MCLK);
    INS_VALID <= 1'b1;
    INS_REQ <= a;
    @(posedge MCLK);
    INS_VALID <= two;
    INS_REQ <= b;
    @(negedge MCLK);
    res = RES;
    @(posedge MCLK);
    INS_VALID <= 1'b0;
    @(negedge MCLK);
    res2 = RES;
  endtask

  function automatic spc_pkg::spc_req_t rq(input spc_pkg::spc_op_t op,
      input logic [1:0] p, input logic [31:0] d);
    rq = '0;
    rq.op = op;
    rq.current_privilege_level = p;
    rq.data = d;
  endfunction

  task automatic one(input spc_pkg::spc_op_t op, input logic [1:0] p,
      input logic [31:0] d);
    exec(rq(op, p, d), 1'b0, rq(op, p, d));
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  initial
  begin
    repeat (5000) @(posedge MCLK);
    miscompares++;
    stop_test;
  end

  initial
  begin
    RST_N = 1'b0;
    INS_VALID = 1'b0;
    INS_REQ = '0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 5'h00;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    miscompares = 0;
    checks_done = 0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    chk("irq reset", {31'h0, IRQ}, 32'h0);
    bus(1'b0, spc_pkg::OFS_CR0, 32'h0);
    chk("ctl zero reset", rd, spc_pkg::CR0_RESET);
    bus(1'b0, spc_pkg::OFS_CR4, 32'h0);
    chk("ctl four reset", rd, spc_pkg::CR4_RESET);
    foreach (priv_ops[i])
    begin
      one(priv_ops[i], i[0] ? spc_pkg::PL_USER : 2'h1, 32'h0);
      chkf(spc_pkg::FLT_GP);
      chk("refused data", res.data, 32'h0);
      one(priv_ops[i], spc_pkg::PL_KERNEL, 32'h0);
      chkf(spc_pkg::FLT_NONE);
    end
    foreach (open_ops[i])
    begin
      one(open_ops[i], spc_pkg::PL_USER, 32'h0);
      chkf(spc_pkg::FLT_NONE);
    end
    q = rq(spc_pkg::OP_LOAD_GLOBAL_TABLE_BASE, spc_pkg::PL_KERNEL, 32'h1234_5678);
    q.limit = 16'h0abc;
    exec(q, 1'b1, rq(spc_pkg::OP_STORE_GLOBAL_TABLE_BASE, spc_pkg::PL_USER, 32'h0));
    chk("valid", {31'h0, res.valid}, 32'h1);
    chk("global base", res2.data, 32'h1234_5678);
    chk("global limit", {16'h0, res2.limit}, 32'h0abc);
    q.op = spc_pkg::OP_LOAD_INTERRUPT_TABLE_BASE;
    q.data = 32'h0bad_cafe;
    q.limit = 16'h0123;
    exec(q, 1'b1, rq(spc_pkg::OP_STORE_INTERRUPT_TABLE_BASE, spc_pkg::PL_USER, 32'h0));
    chk("intr base", res2.data, 32'h0bad_cafe);
    chk("intr limit", {16'h0, res2.limit}, 32'h0123);
    q.op = spc_pkg::OP_LOAD_GLOBAL_TABLE_BASE;
    q.current_privilege_level = spc_pkg::PL_USER;
    exec(q, 1'b1, rq(spc_pkg::OP_STORE_GLOBAL_TABLE_BASE, spc_pkg::PL_USER, 32'h0));
    chk("global kept", res2.data, 32'h1234_5678);
    q = rq(spc_pkg::OP_LOAD_LOCAL_TABLE_SELECTOR, spc_pkg::PL_KERNEL, 32'h0);
    q.sel = 16'h0028;
    exec(q, 1'b1, rq(spc_pkg::OP_STORE_LOCAL_TABLE_SELECTOR, spc_pkg::PL_USER, 32'h0));
    chk("local sel", {16'h0, res2.data[15:0]}, 32'h0028);
    q.op = spc_pkg::OP_LTR;
    q.sel = 16'h0030;
    exec(q, 1'b1, rq(spc_pkg::OP_STR, spc_pkg::PL_USER, 32'h0));
    chk("task sel", {16'h0, res2.data[15:0]}, 32'h0030);
    bus(1'b0, spc_pkg::OFS_SEL, 32'h0);
    chk("sel reg", rd, 32'h0028_0030);
    one(spc_pkg::OP_MOV_TO_CR, spc_pkg::PL_KERNEL, 32'hffff_0000);
    one(spc_pkg::OP_LOAD_LOW_CONTROL_WORD, spc_pkg::PL_KERNEL, 32'h5555_1231);
    bus(1'b0, spc_pkg::OFS_CR0, 32'h0);
    chk("low word load", rd, 32'hffff_1231);
    one(spc_pkg::OP_STORE_LOW_CONTROL_WORD, spc_pkg::PL_USER, 32'h0);
    chk("low word store", {16'h0, res.data[15:0]}, 32'h1231);
    one(spc_pkg::OP_MOV_FROM_CR, spc_pkg::PL_KERNEL, 32'h0);
    chk("move from", res.data, 32'hffff_1231);
    q = rq(spc_pkg::OP_MOV_TO_CR, spc_pkg::PL_KERNEL, 32'h00c0_ffee);
    q.cr_idx = 3'h2;
    exec(q, 1'b0, q);
    q.op = spc_pkg::OP_MOV_FROM_CR;
    exec(q, 1'b0, q);
    chk("move two", res.data, 32'h00c0_ffee);
    q.cr_idx = 3'h5;
    exec(q, 1'b0, q);
    chkf(spc_pkg::FLT_GP);
    bus(1'b1, spc_pkg::OFS_CR0, 32'h0000_0008);
    one(spc_pkg::OP_FPU, spc_pkg::PL_USER, 32'h0);
    chkf(spc_pkg::FLT_NM);
    one(spc_pkg::OP_CLEAR_SWITCHED_FLAG_OP, spc_pkg::PL_KERNEL, 32'h0);
    one(spc_pkg::OP_FPU, spc_pkg::PL_USER, 32'h0);
    chkf(spc_pkg::FLT_NONE);
    bus(1'b0, spc_pkg::OFS_CR0, 32'h0);
    chk("flag cleared", rd, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, spc_pkg::OFS_CR4, (32'(k[0]) << spc_pkg::CR4_TSD_BIT)
        | (32'(k[1]) << spc_pkg::CR4_PCE_BIT));
      pl = k[2] ? spc_pkg::PL_USER : spc_pkg::PL_KERNEL;
      one(spc_pkg::OP_READ_TIMESTAMP_OP, pl, 32'h0);
      chkf(k[0] && k[2] ? spc_pkg::FLT_GP : spc_pkg::FLT_NONE);
      one(spc_pkg::OP_READ_PERF_COUNTER_OP, pl, 32'h0);
      chkf(!k[1] && k[2] ? spc_pkg::FLT_GP : spc_pkg::FLT_NONE);
    end
    q = rq(spc_pkg::OP_READ_PERF_COUNTER_OP, spc_pkg::PL_KERNEL, 32'h0);
    exec(q, 1'b1, q);
    chk("counter step", res2.data, res.data + 32'h1);
    q.op = spc_pkg::OP_READ_TIMESTAMP_OP;
    exec(q, 1'b1, q);
    chk("stamp step", res2.data, res.data + 32'h1);
    q = rq(spc_pkg::OP_ADJUST_REQUESTOR_LEVEL, spc_pkg::PL_USER, 32'h0000_0003);
    q.sel = 16'h0048;
    exec(q, 1'b0, q);
    chk("adjusted", {16'h0, res.data[15:0]}, 32'h004b);
    chk("adjust zf", {31'h0, res.zf}, 32'h1);
    q.sel = 16'h004b;
    q.data = 32'h1;
    exec(q, 1'b0, q);
    chk("kept", {16'h0, res.data[15:0]}, 32'h004b);
    chk("kept zf", {31'h0, res.zf}, 32'h0);
    q = rq(spc_pkg::OP_LAR, spc_pkg::PL_USER, 32'h0);
    q.sel = 16'h0053;
    q.rights = 8'hf2;
    q.seg_limit = 20'h0_1fff;
    exec(q, 1'b0, q);
    chk("rights", res.data, 32'h0000_f200);
    chk("rights zf", {31'h0, res.zf}, 32'h1);
    q.op = spc_pkg::OP_LSL;
    exec(q, 1'b0, q);
    chk("limit", res.data, 32'h0000_1fff);
    chk("limit zf", {31'h0, res.zf}, 32'h1);
    q.op = spc_pkg::OP_VERIFY_WRITABLE_OP;
    exec(q, 1'b0, q);
    chk("writable", {31'h0, res.zf}, 32'h1);
    q.rights = 8'hf0;
    exec(q, 1'b0, q);
    chk("not writable", {31'h0, res.zf}, 32'h0);
    chkf(spc_pkg::FLT_NONE);
    q.op = spc_pkg::OP_VERIFY_READABLE_OP;
    exec(q, 1'b0, q);
    chk("readable", {31'h0, res.zf}, 32'h1);
    q.rights = 8'h92;
    exec(q, 1'b0, q);
    chk("too high", {31'h0, res.zf}, 32'h0);
    q.op = spc_pkg::OP_LAR;
    q.rights = 8'h72;
    exec(q, 1'b0, q);
    chk("absent", {31'h0, res.zf}, 32'h0);
    bus(1'b1, spc_pkg::OFS_IRQ_CLR, 32'hf);
    bus(1'b1, spc_pkg::OFS_IRQ_EN, 32'h0);
    one(spc_pkg::OP_HLT, spc_pkg::PL_USER, 32'h0);
    chk("irq masked", {31'h0, IRQ}, 32'h0);
    bus(1'b0, spc_pkg::OFS_STATUS, 32'h0);
    chk("gp status", {31'h0, rd[spc_pkg::EV_GP]}, 32'h1);
    bus(1'b1, spc_pkg::OFS_IRQ_EN, 32'h1);
    bus(1'b0, spc_pkg::OFS_IRQ_EN, 32'h0);
    chk("enable", rd, 32'h1);
    chk("irq high", {31'h0, IRQ}, 32'h1);
    bus(1'b1, spc_pkg::OFS_IRQ_CLR, 32'h1);
    bus(1'b0, spc_pkg::OFS_IRQ_CLR, 32'h0);
    chk("clear reads", rd, 32'h0);
    chk("irq cleared", {31'h0, IRQ}, 32'h0);
    AVS_BYTEENABLE <= 4'h2;
    bus(1'b1, spc_pkg::OFS_CR0, 32'hffff_ffff);
    AVS_BYTEENABLE <= 4'hf;
    bus(1'b0, spc_pkg::OFS_CR0, 32'h0);
    chk("byte lane", rd, 32'h0000_ff00);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", rd, 32'h0);
    stop_test;
  end
endmodule
